// ### rtl/ctim_irq_monitor.sv
// Interrupt event monitor of the dual-loop clock translator
// Behaviour
// - An unmasked event sets its monitor flag to one.
// - Flags stay set until reset, clear-all or per-bit clear write.
// - Common bit 6 on system PLL unlock, 4 on lock, 5 stable.
// - Common bit 3 latches on watchdog expiry.
// - Common bit 1 on EEPROM fault, bit 0 on EEPROM success.
// - Ref A/B register: faulted, cleared, validated in bits 0-2, 4-6.
// - Ref C/D register: faulted, cleared, validated in bits 0-2, 4-6.
// - Loop 0: phase lock gain/loss bits 0-1, frequency bits 2-3.
// - Loop 0: slew limit entry/exit bits 4-5, clamp bits 6-7.
// - Loop 0 state bits 0-3 on activating reference A to D.
// - Loop 0 state: history 4, holdover 5, free run 6, switch 7.
// - Analog loop 0: cal start, cal done, lock, unlock bits 0-3.
// - Analog register bit 4 on a distribution sync event.
// - Loop 1 lock register mirrors loop 0 lock layout.
// - Loop 1 state register mirrors loop 0 state layout.
// - Analog loop 1: cal start, cal done, lock, unlock bits 0-3.
`timescale 1ns/10ps
`include "ctim_consts.svh"
module ctim_irq_monitor (
  // Clock, reset, enable
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic CE,
  // AXI4-Lite write address
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [15:0] AWADDR,
  // AXI4-Lite write data
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  // AXI4-Lite write response
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  // AXI4-Lite read address
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [15:0] ARADDR,
  // AXI4-Lite read data
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  // Common status levels
  input wire logic SYS_PLL_LOCK,
  input wire logic SYS_PLL_STABLE,
  input wire logic WDOG_EXPIRED,
  input wire logic EEPROM_OK,
  input wire logic EEPROM_FAULT,
  // Reference status, bit 0 is reference A
  input wire logic [3:0] REF_FAULT,
  input wire logic [3:0] REF_VALID,
  // Digital loop status, bit 0 is loop 0
  input wire logic [1:0] DL_PHASE_LOCK,
  input wire logic [1:0] DL_FREQ_LOCK,
  input wire logic [1:0] DL_SLEW_LIMIT,
  input wire logic [1:0] DL_FREQ_CLAMP,
  input wire logic [7:0] DL_REF_ACTIVE,
  input wire logic [1:0] DL_HIST_UPD,
  input wire logic [1:0] DL_HOLDOVER,
  input wire logic [1:0] DL_FREE_RUN,
  input wire logic [1:0] DL_SWITCHING,
  // Analog loop status, bit 0 is loop 0
  input wire logic [1:0] AL_CAL_BUSY,
  input wire logic [1:0] AL_LOCK,
  input wire logic [1:0] AL_SYNC_DIST,
  // Interrupt
  output logic IRQ
);
  localparam logic [8:0][7:0] FALL_TAB = {
    `CTIM_FALL_ANALOG, `CTIM_FALL_STATE, `CTIM_FALL_LOCK,
    `CTIM_FALL_ANALOG, `CTIM_FALL_STATE, `CTIM_FALL_LOCK,
    `CTIM_FALL_REF, `CTIM_FALL_REF, `CTIM_FALL_COMMON};
  localparam logic [8:0][7:0] IMPL_TAB = {
    `CTIM_IMPL_ANALOG, `CTIM_IMPL_STATE, `CTIM_IMPL_LOCK,
    `CTIM_IMPL_ANALOG, `CTIM_IMPL_STATE, `CTIM_IMPL_LOCK,
    `CTIM_IMPL_REF, `CTIM_IMPL_REF, `CTIM_IMPL_COMMON};

  ctim_pkg::ctim_top_state_t s_q;
  ctim_pkg::ctim_top_state_t s_d;
  logic [8:0][7:0] lv;
  logic [8:0][7:0] flag;
  logic [8:0] grp_any;

  // Status levels arranged as the flag registers see them
  always_comb begin
    lv = '0;
    // system PLL lock both ways, stable
    lv[0][`CTIM_BIT_SYS_UNLOCK] = SYS_PLL_LOCK;
    lv[0][`CTIM_BIT_SYS_STABLE] = SYS_PLL_STABLE;
    lv[0][`CTIM_BIT_SYS_LOCK] = SYS_PLL_LOCK;
    lv[0][`CTIM_BIT_WDOG] = WDOG_EXPIRED;
    lv[0][`CTIM_BIT_EE_FAULT] = EEPROM_FAULT;
    lv[0][`CTIM_BIT_EE_OK] = EEPROM_OK;
    lv[1] = {1'b0, REF_VALID[1], REF_FAULT[1], REF_FAULT[1],
             1'b0, REF_VALID[0], REF_FAULT[0], REF_FAULT[0]};
    lv[2] = {1'b0, REF_VALID[3], REF_FAULT[3], REF_FAULT[3],
             1'b0, REF_VALID[2], REF_FAULT[2], REF_FAULT[2]};
    for (int k = 0; k < 2; k++) begin
      // phase and frequency lock, slew and clamp entry and exit
      lv[3 + 3 * k] = {DL_FREQ_CLAMP[k], DL_FREQ_CLAMP[k],
                       DL_SLEW_LIMIT[k], DL_SLEW_LIMIT[k],
                       DL_FREQ_LOCK[k], DL_FREQ_LOCK[k],
                       DL_PHASE_LOCK[k], DL_PHASE_LOCK[k]};
      lv[4 + 3 * k] = {DL_SWITCHING[k], DL_FREE_RUN[k],
                       DL_HOLDOVER[k], DL_HIST_UPD[k],
                       DL_REF_ACTIVE[4 * k +: 4]};
      lv[5 + 3 * k][3:0] = {AL_LOCK[k], AL_LOCK[k],
                            AL_CAL_BUSY[k], AL_CAL_BUSY[k]};
      lv[5 + 3 * k][`CTIM_BIT_SYNC_DIST] = AL_SYNC_DIST[k];
    end
  end

  genvar g;
  generate
    for (g = 0; g < `CTIM_NUM_REGS; g++) begin : g_flags
      ctim_flag_reg #(
        .FALL(FALL_TAB[g]),
        .IMPL(IMPL_TAB[g])
      ) u_flag (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .ce(CE),
        .lvl(lv[g]),
        .mask(s_q.mask[g]),
        .clr(s_q.clr[g]),
        .clr_all(s_q.clr_all),
        .flags(flag[g])
      );
      assign grp_any[g] = |flag[g];
    end
  endgenerate

  // Bus slave and control registers
  always_comb begin
    logic [15:0] widx;
    logic [15:0] ridx;
    logic hit;
    widx = {2'b00, s_q.aw_addr[15:2]};
    ridx = {2'b00, ARADDR[15:2]};
    hit = 1'b0;
    s_d = s_q;
    // Clear strobes last one cycle
    s_d.clr = '0;
    s_d.clr_all = 1'b0;

    if (AWVALID && s_q.awready) begin
      s_d.aw_got = 1'b1;
      s_d.aw_addr = AWADDR;
    end
    if (WVALID && s_q.wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = WDATA[8:0];
      s_d.wstrb0 = WSTRB[0];
    end

    // Write takes effect once address and data are both held
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      for (int i = 0; i < `CTIM_NUM_REGS; i++) begin
        if (widx == 16'(`CTIM_IDX_FLAGS_COMMON + i)) begin
          // Flags are read only; the write is accepted and dropped
          hit = 1'b1;
        end
        if (widx == 16'(`CTIM_IDX_MASK_BASE + i)) begin
          hit = 1'b1;
          if (s_q.wstrb0) begin
            s_d.mask[i] = s_q.wdata[7:0];
          end
        end
        if (widx == 16'(`CTIM_IDX_CLR_BASE + i)) begin
          hit = 1'b1;
          if (s_q.wstrb0) begin
            s_d.clr[i] = s_q.wdata[7:0];
          end
        end
      end
      if (widx == `CTIM_IDX_CLR_ALL) begin
        hit = 1'b1;
        if (s_q.wstrb0) begin
          s_d.clr_all = s_q.wdata[`CTIM_CLR_ALL_BIT];
        end
      end
      if (widx == `CTIM_IDX_IRQ_EN) begin
        hit = 1'b1;
        if (s_q.wstrb0) begin
          s_d.irq_en = s_q.wdata;
        end
      end
      s_d.bresp = hit ? `CTIM_RESP_OKAY : `CTIM_RESP_SLVERR;
    end else if (s_q.bvalid && BREADY) begin
      s_d.bvalid = 1'b0;
    end
    // One write in flight: both channels close until B completes
    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready = !s_d.w_got && !s_d.bvalid;

    // Reads answer one cycle after the address is taken
    if (ARVALID && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = 8'h00;
      s_d.rresp = `CTIM_RESP_SLVERR;
      for (int i = 0; i < `CTIM_NUM_REGS; i++) begin
        if (ridx == 16'(`CTIM_IDX_FLAGS_COMMON + i)) begin
          s_d.rdata = flag[i];
          s_d.rresp = `CTIM_RESP_OKAY;
        end
        if (ridx == 16'(`CTIM_IDX_MASK_BASE + i)) begin
          s_d.rdata = s_q.mask[i];
          s_d.rresp = `CTIM_RESP_OKAY;
        end
        if (ridx == 16'(`CTIM_IDX_CLR_BASE + i)) begin
          s_d.rresp = `CTIM_RESP_OKAY;
        end
      end
      if (ridx == `CTIM_IDX_CLR_ALL) begin
        s_d.rresp = `CTIM_RESP_OKAY;
      end
      if (ridx == `CTIM_IDX_IRQ_EN) begin
        s_d.rdata = s_q.irq_en[7:0];
        s_d.rresp = `CTIM_RESP_OKAY;
      end
    end else if (s_q.rvalid && RREADY) begin
      s_d.rvalid = 1'b0;
    end
    s_d.arready = !s_d.rvalid;

    // Level interrupt, one flop behind the flags
    s_d.irq = |(grp_any & s_q.irq_en);
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      s_q <= '0;
      s_q.mask <= {`CTIM_NUM_REGS{`CTIM_MASK_RST}};
      s_q.irq_en <= `CTIM_IRQ_EN_RST;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  assign AWREADY = s_q.awready;
  assign WREADY = s_q.wready;
  assign BVALID = s_q.bvalid;
  assign BRESP = s_q.bresp;
  assign ARREADY = s_q.arready;
  assign RVALID = s_q.rvalid;
  // Bit 8 of the enable word is not readable; upper bits are zero
  assign RDATA = {24'h000000, s_q.rdata};
  assign RRESP = s_q.rresp;
  assign IRQ = s_q.irq;

  a_sys_unlock: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N)
    $past(RST_N) && $past(CE) && CE && $fell(SYS_PLL_LOCK)
      && !s_q.mask[0][`CTIM_BIT_SYS_UNLOCK]
      |=> flag[0][`CTIM_BIT_SYS_UNLOCK])
    else $error("system PLL unlock not flagged");

  a_wdog_flag: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N)
    $past(RST_N) && $past(CE) && CE && $rose(WDOG_EXPIRED)
      && !s_q.mask[0][`CTIM_BIT_WDOG] |=> flag[0][`CTIM_BIT_WDOG])
    else $error("watchdog expiry not flagged");

  a_ref_cleared: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N)
    $past(RST_N) && $past(CE) && CE && $fell(REF_FAULT[1])
      && !s_q.mask[1][5] |=> flag[1][5])
    else $error("reference B fault clear not flagged");

  a_sync_dist: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N)
    $past(RST_N) && $past(CE) && CE && $rose(AL_SYNC_DIST[1])
      && !s_q.mask[8][`CTIM_BIT_SYNC_DIST]
      |=> flag[8][`CTIM_BIT_SYNC_DIST])
    else $error("loop 1 sync event not flagged");

  a_clear_all: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N)
    CE && s_q.aw_got && s_q.w_got && !s_q.bvalid && s_q.wstrb0
      && (s_q.aw_addr[15:2] == 14'(`CTIM_IDX_CLR_ALL))
      && s_q.wdata[`CTIM_CLR_ALL_BIT] |=> s_q.clr_all ##1 !s_q.clr_all)
    else $error("clear all strobe not one cycle");

  a_irq_level: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    CE |=> IRQ == $past(|(grp_any & s_q.irq_en)))
    else $error("interrupt does not follow enabled flags");

  a_read_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read answer dropped before taken");

  a_eeprom_done: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N)
    $past(RST_N) && $past(CE) && CE && $rose(EEPROM_OK)
      && !s_q.mask[0][`CTIM_BIT_EE_OK] |=> flag[0][`CTIM_BIT_EE_OK])
    else $error("EEPROM completion not flagged");

  a_ref_valid: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N)
    $past(RST_N) && $past(CE) && CE && $rose(REF_VALID[3])
      && !s_q.mask[2][6] |=> flag[2][6])
    else $error("reference D validation not flagged");

  a_phase_lock: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N)
    $past(RST_N) && $past(CE) && CE && $rose(DL_PHASE_LOCK[0])
      && !s_q.mask[3][0] |=> flag[3][0])
    else $error("loop 0 phase lock not flagged");

  a_slew_exit: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N)
    $past(RST_N) && $past(CE) && CE && $fell(DL_SLEW_LIMIT[0])
      && !s_q.mask[3][5] |=> flag[3][5])
    else $error("loop 0 slew limit exit not flagged");

  a_ref_active: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N)
    $past(RST_N) && $past(CE) && CE && $rose(DL_REF_ACTIVE[2])
      && !s_q.mask[4][2] |=> flag[4][2])
    else $error("loop 0 reference C activation not flagged");

  a_loop1_switch: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N)
    $past(RST_N) && $past(CE) && CE && $rose(DL_SWITCHING[1])
      && !s_q.mask[7][7] |=> flag[7][7])
    else $error("loop 1 reference switch not flagged");

  a_cal_done: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N)
    $past(RST_N) && $past(CE) && CE && $fell(AL_CAL_BUSY[1])
      && !s_q.mask[8][1] |=> flag[8][1])
    else $error("analog loop 1 calibration end not flagged");
endmodule

// ### pkg/ctim_consts.svh
// Offsets, field layouts and reset values of the event flag block
`ifndef CTIM_CONSTS_SVH
`define CTIM_CONSTS_SVH

`define CTIM_NUM_REGS 9
`define CTIM_AXI_AW 16

// Register indices; the byte address is four times the index
`define CTIM_IDX_FLAGS_COMMON 16'h0d08
`define CTIM_IDX_FLAGS_REF_A_B 16'h0d09
`define CTIM_IDX_FLAGS_REF_C_D 16'h0d0a
`define CTIM_IDX_FLAGS_LOOP0_LOCK 16'h0d0b
`define CTIM_IDX_FLAGS_LOOP0_STATE 16'h0d0c
`define CTIM_IDX_FLAGS_LOOP0_ANALOG 16'h0d0d
`define CTIM_IDX_FLAGS_LOOP1_LOCK 16'h0d0e
`define CTIM_IDX_FLAGS_LOOP1_STATE 16'h0d0f
`define CTIM_IDX_FLAGS_LOOP1_ANALOG 16'h0d10
`define CTIM_IDX_MASK_BASE 16'h010a
`define CTIM_IDX_CLR_ALL 16'h0a05
`define CTIM_IDX_CLR_BASE 16'h0a06
`define CTIM_IDX_IRQ_EN 16'h0a0f

// Field positions
`define CTIM_CLR_ALL_BIT 0
`define CTIM_BIT_SYS_UNLOCK 6
`define CTIM_BIT_SYS_STABLE 5
`define CTIM_BIT_SYS_LOCK 4
`define CTIM_BIT_WDOG 3
`define CTIM_BIT_EE_FAULT 1
`define CTIM_BIT_EE_OK 0
`define CTIM_BIT_SYNC_DIST 4

// Reset values
`define CTIM_MASK_RST 8'h00
`define CTIM_IRQ_EN_RST 9'h1ff

// Bits caught on a falling level, and bits that exist, per register kind
`define CTIM_FALL_COMMON 8'h40
`define CTIM_IMPL_COMMON 8'h7b
`define CTIM_FALL_REF 8'h22
`define CTIM_IMPL_REF 8'h77
`define CTIM_FALL_LOCK 8'haa
`define CTIM_IMPL_LOCK 8'hff
`define CTIM_FALL_STATE 8'h00
`define CTIM_IMPL_STATE 8'hff
`define CTIM_FALL_ANALOG 8'h0a
`define CTIM_IMPL_ANALOG 8'h1f

// Bus answers
`define CTIM_RESP_OKAY 2'h0
`define CTIM_RESP_SLVERR 2'h2

`endif

// ### pkg/ctim_pkg.sv
// State types of the event flag block
package ctim_pkg;

  typedef struct packed {
    logic primed;
    logic [7:0] prev;
    logic [7:0] flags;
  } ctim_flag_state_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [15:0] aw_addr;
    logic [8:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [8:0][7:0] mask;
    logic [8:0][7:0] clr;
    logic clr_all;
    logic [8:0] irq_en;
    logic irq;
  } ctim_top_state_t;

endpackage

// ### rtl/ctim_flag_reg.sv
// Eight sticky event flags with edge detection, mask and clears
`timescale 1ns/10ps
module ctim_flag_reg #(
  parameter logic [7:0] FALL = 8'h00,
  parameter logic [7:0] IMPL = 8'hff
) (
  // Clock and control
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Status levels and software controls
  input wire logic [7:0] lvl,
  input wire logic [7:0] mask,
  input wire logic [7:0] clr,
  input wire logic clr_all,
  // Flags
  output logic [7:0] flags
);
  ctim_pkg::ctim_flag_state_t s_q;
  ctim_pkg::ctim_flag_state_t s_d;
  logic [7:0] ev;
  logic [7:0] setv;

  always_comb begin
    ev = (lvl & ~s_q.prev & ~FALL) | (~lvl & s_q.prev & FALL);
    // First cycle after reset only learns the levels
    ev = s_q.primed ? (ev & IMPL) : 8'h00;
    setv = ev & ~mask;
    s_d = s_q;
    s_d.primed = 1'b1;
    s_d.prev = lvl;
    s_d.flags = s_q.flags & ~(clr_all ? 8'hff : clr);
    s_d.flags = s_d.flags | setv;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign flags = s_q.flags;

  a_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    ce && (setv != 8'h00) |=> (flags & $past(setv)) == $past(setv))
    else $error("unmasked event did not set its flag");

  a_masked_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    ce && (setv == 8'h00) |=> (flags & ~$past(flags)) == 8'h00)
    else $error("flag rose without an unmasked event");

  a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    !clr_all && (clr == 8'h00) |=> (flags & $past(flags)) == $past(flags))
    else $error("flag dropped without a clear");

  a_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
    ce && clr_all |=> flags == $past(setv))
    else $error("clear all did not leave exactly the new events");
endmodule

// ### sim/ctim_irq_monitor_bench.sv
// Self-checking bench of the event flag block
`timescale 1ns/10ps
`include "ctim_consts.svh"
module ctim_irq_monitor_bench;
  logic CLK_SYS, RST_N, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic ARVALID, ARREADY, RVALID, RREADY, IRQ, CE;
  logic [15:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, d;
  logic [3:0] WSTRB, strb;
  logic [1:0] BRESP, RRESP, rsp;
  logic [42:0] st;
  int n_fail, checks_done, rdly;
  // Row: status bit [15:8], register [7:4], falling edge [3], flag bit [2:0]
  logic [15:0] rows [60] = '{16'h0004, 16'h000e, 16'h0105, 16'h0203,
    16'h0300, 16'h0401, 16'h0510, 16'h0519, 16'h0614, 16'h061d, 16'h0720,
    16'h0729, 16'h0824, 16'h082d, 16'h0912, 16'h0a16, 16'h0b22, 16'h0c26,
    16'h0d30, 16'h0d39, 16'h0e60, 16'h0e69, 16'h0f32, 16'h0f3b, 16'h1062,
    16'h106b, 16'h1134, 16'h113d, 16'h1264, 16'h126d, 16'h1336, 16'h133f,
    16'h1466, 16'h146f, 16'h1540, 16'h1641, 16'h1742, 16'h1843, 16'h1970,
    16'h1a71, 16'h1b72, 16'h1c73, 16'h1d44, 16'h1e74, 16'h1f45, 16'h2075,
    16'h2146, 16'h2276, 16'h2347, 16'h2477, 16'h2550, 16'h2559, 16'h2680,
    16'h2689, 16'h2752, 16'h275b, 16'h2882, 16'h288b, 16'h2954, 16'h2a84};

  ctim_irq_monitor dut (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .CE(CE),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
    .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
    .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
    .SYS_PLL_LOCK(st[0]), .SYS_PLL_STABLE(st[1]), .WDOG_EXPIRED(st[2]),
    .EEPROM_OK(st[3]), .EEPROM_FAULT(st[4]), .REF_FAULT(st[8:5]),
    .REF_VALID(st[12:9]), .DL_PHASE_LOCK(st[14:13]),
    .DL_FREQ_LOCK(st[16:15]), .DL_SLEW_LIMIT(st[18:17]),
    .DL_FREQ_CLAMP(st[20:19]), .DL_REF_ACTIVE(st[28:21]),
    .DL_HIST_UPD(st[30:29]), .DL_HOLDOVER(st[32:31]),
    .DL_FREE_RUN(st[34:33]), .DL_SWITCHING(st[36:35]),
    .AL_CAL_BUSY(st[38:37]), .AL_LOCK(st[40:39]), .AL_SYNC_DIST(st[42:41]),
    .IRQ(IRQ));

  initial begin
    CLK_SYS = 1'b0;
    forever #4 CLK_SYS = ~CLK_SYS;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic hang();
    n_fail++;
    $display("unexpected at %0t: bus answer missing", $time);
  endtask

  // Both channels offered together, each dropped when taken
  task automatic wr(input logic [15:0] idx, input logic [31:0] v);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge CLK_SYS);
    AWVALID <= 1'b1;
    AWADDR <= {idx[13:0], 2'b00};
    WVALID <= 1'b1;
    WDATA <= v;
    WSTRB <= strb;
    BREADY <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      n++;
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
      if (BVALID === 1'b1) begin
        rsp = BRESP;
        BREADY <= 1'b0;
        done = 1'b1;
      end
    end while (!done && n < 50);
    if (!done) hang();
  endtask

  task automatic rd(input logic [15:0] idx, output logic [31:0] v);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    v = 32'hx;
    @(posedge CLK_SYS);
    ARVALID <= 1'b1;
    ARADDR <= {idx[13:0], 2'b00};
    // Ready may come late, so the answer has to wait for it
    RREADY <= (rdly == 0);
    do begin
      @(posedge CLK_SYS);
      n++;
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
      if (RVALID === 1'b1 && RREADY) begin
        v = RDATA;
        rsp = RRESP;
        RREADY <= 1'b0;
        done = 1'b1;
      end else if (n >= rdly) begin
        RREADY <= 1'b1;
      end
    end while (!done && n < 50);
    if (!done) hang();
  endtask

  task automatic clr_all();
    wr(`CTIM_IDX_CLR_ALL, 32'h1);
    repeat (3) @(posedge CLK_SYS);
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Whole run is about a thousand cycles; far beyond that means a hang
  initial begin
    #160000;
    n_fail++;
    stop_test();
  end

  initial begin
    logic [15:0] r;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
    AWADDR = 16'h0000;
    ARADDR = 16'h0000;
    WDATA = 32'h0;
    WSTRB = 4'hf;
    strb = 4'hf;
    st = '0;
    CE = 1'b1;
    RST_N = 1'b0;
    repeat (12) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    for (int i = 0; i < 60; i++) begin
      r = rows[i];
      check(32'(IRQ), 32'h0);
      if (r[3]) begin
        st[r[15:8]] <= 1'b1;
        clr_all();
      end
      st[r[15:8]] <= ~r[3];
      repeat (3) @(posedge CLK_SYS);
      check(32'(IRQ), 32'h1);
      rd(`CTIM_IDX_FLAGS_COMMON + 16'(r[7:4]), d);
      check(d, 32'h1 << r[2:0]);
      st[r[15:8]] <= 1'b0;
      clr_all();
    end
    // Watchdog edge lands on the very edge that clear-all hits the flags
    fork
      clr_all();
      begin
        @(posedge CLK_SYS iff !AWREADY);
        st[2] <= 1'b1;
      end
    join
    rd(`CTIM_IDX_FLAGS_COMMON, d);
    check(d, 32'h08);
    st[2] <= 1'b0;
    st[9] <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    st[9] <= 1'b0;
    repeat (3) @(posedge CLK_SYS);
    wr(`CTIM_IDX_CLR_BASE, 32'h08);
    check(32'(rsp), 32'(`CTIM_RESP_OKAY));
    rd(`CTIM_IDX_FLAGS_COMMON, d);
    check(d, 32'h0);
    rdly = 3;
    rd(`CTIM_IDX_FLAGS_REF_A_B, d);
    rdly = 0;
    check(d, 32'h04);
    check(32'(rsp), 32'(`CTIM_RESP_OKAY));
    wr(`CTIM_IDX_FLAGS_REF_A_B, 32'h0);
    check(32'(rsp), 32'(`CTIM_RESP_OKAY));
    rd(`CTIM_IDX_FLAGS_REF_A_B, d);
    check(d, 32'h04);
    wr(`CTIM_IDX_IRQ_EN, 32'h1fd);
    repeat (2) @(posedge CLK_SYS);
    check(32'(IRQ), 32'h0);
    wr(`CTIM_IDX_IRQ_EN, 32'h1ff);
    repeat (2) @(posedge CLK_SYS);
    check(32'(IRQ), 32'h1);
    // Mask blocks the lock edge only; byte strobe off leaves it unchanged
    wr(`CTIM_IDX_MASK_BASE, 32'h10);
    strb = 4'he;
    wr(`CTIM_IDX_MASK_BASE, 32'hff);
    strb = 4'hf;
    rd(`CTIM_IDX_MASK_BASE, d);
    check(d, 32'h10);
    st[0] <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    rd(`CTIM_IDX_FLAGS_COMMON, d);
    check(d, 32'h0);
    wr(`CTIM_IDX_MASK_BASE, 32'h0);
    st[0] <= 1'b0;
    repeat (3) @(posedge CLK_SYS);
    rd(`CTIM_IDX_FLAGS_COMMON, d);
    check(d, 32'h40);
    rd(16'h0d11, d);
    check({d[29:0], rsp}, {30'h0, `CTIM_RESP_SLVERR});
    wr(16'h0d11, 32'hff);
    check(32'(rsp), 32'(`CTIM_RESP_SLVERR));
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    check(32'(IRQ), 32'h0);
    rd(`CTIM_IDX_FLAGS_REF_A_B, d);
    check(d, 32'h0);
    rd(`CTIM_IDX_IRQ_EN, d);
    check(d, 32'hff);
    // Frozen cycles must neither flag nor lose the EEPROM edge
    CE <= 1'b0;
    st[3] <= 1'b1;
    repeat (4) @(posedge CLK_SYS);
    check(32'(IRQ), 32'h0);
    CE <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    check(32'(IRQ), 32'h1);
    rd(`CTIM_IDX_FLAGS_COMMON, d);
    check(d, 32'h01);
    stop_test();
  end
endmodule
